// file: hw/spi_port_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH
`define OFS_MISC_CTRL 4'h0
`define OFS_PORT_CTRL 4'h4
`define OFS_PORT_STAT 4'h8
`define OFS_SHIFT_DATA 4'hc
`define OFS_PIN_DIR 4'h0
`define BIT_PIN_ROUTE 7
`define BIT_IRQ_EN 7
`define BIT_PORT_EN 6
`define BIT_ORDER_LSB 5
`define BIT_CTRL_SEL 4
`define BIT_IDLE_LVL 3
`define BIT_PHASE 2
`define BIT_DONE 7
`define BIT_WRITE_COLLISION_FLAG 6
`define BIT_DBL 0
`define RST_MISC_CTRL 8'h00
`define RST_PORT_CTRL 8'h00
`define RST_PORT_STAT 8'h00
`define BITS_PER_BYTE 4'h8
`define PKG_32_PIN 1'b1
`endif

// file: hw/spi_port_pkg.sv
// Types shared by the serial port files
package spi_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b10
  } ctl_state_type;
endpackage

// file: hw/sck_divider.sv
// Half-period tick generator for controller SCK
`timescale 1ns/1ps
`include "spi_port_params.svh"
module sck_divider
  import spi_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] rate_sel,
  input wire logic double_rate,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
  } div_state_type;
  div_state_type s_q;
  div_state_type s_d;
  logic [6:0] half_m1;

  // Divider table lookup
  function automatic logic [6:0] half_period(input logic [1:0] sel, input logic dbl);
    logic [7:0] full;
    full = 8'h04;
    unique case ({dbl, sel})
      3'b000: full = 8'h04;
      3'b001: full = 8'h10;
      3'b010: full = 8'h40;
      3'b011: full = 8'h80;
      3'b100: full = 8'h02;
      3'b101: full = 8'h08;
      3'b110: full = 8'h20;
      3'b111: full = 8'h40;
    endcase
    half_period = full[7:1] - 7'h01;
  endfunction

  always_comb begin
    half_m1 = half_period(rate_sel, double_rate);
    s_d = s_q;
    tick = 1'b0;
    if (!run) begin
      s_d.cnt = 7'h00;
    end else if (s_q.cnt >= half_m1) begin
      s_d.cnt = 7'h00;
      tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // sck_divider

// file: hw/spi_port.sv
// Serial peripheral port with Avalon-MM register slave
`timescale 1ns/1ps
`include "spi_port_params.svh"
// Functional notes
// - Peripheral: select input; MISO drives when low
// - Select high resets peripheral bit count after two-cycle sync
// - Select output in controller: plain output
// - Select-input low drops controller role
// - Role loss sets done flag, may interrupt
// - Route bit picks pin set, package-dependent
// - Interrupt when done, enabled, globally enabled
// - Enable bit gates all serial operation
// - Order bit chooses LSB or MSB first
// - Idle level bit sets SCK idle
// - Phase bit picks sample/setup edge
// - Controller divider from rate and double
// - Done flag set; cleared status-then-data
// - Collision flag on write during transfer
// - Status bits five to one read zero
// - Data write starts; read returns buffer
// - Shift and sample on opposite edges
// - Double bit halves controller SCK period
// - Controller stops after eight bits
// - Receive double buffered, overwritten on completion
module spi_port
  import spi_port_pkg::*;
#(
  parameter logic PKG_IS_32 = `PKG_32_PIN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic global_irq_enable,
  input wire logic vector_taken,
  input wire logic ss_dir_out,
  input wire logic mosi_dir_out,
  input wire logic sck_dir_out,
  input wire logic miso_dir_out,
  input wire logic ss_gpio_out,
  input wire logic [1:0] ss_in,
  input wire logic [1:0] sck_in,
  input wire logic [1:0] mosi_in,
  input wire logic [1:0] miso_in,
  output logic [1:0] ss_out,
  output logic [1:0] ss_oe_n,
  output logic [1:0] sck_out,
  output logic [1:0] sck_oe_n,
  output logic [1:0] mosi_out,
  output logic [1:0] mosi_oe_n,
  output logic [1:0] miso_out,
  output logic [1:0] miso_oe_n,
  output logic xfer_irq
);
  typedef struct packed {
    logic [7:0] misc_ctrl;
    logic [7:0] port_ctrl;
    logic done;
    logic write_collision_flag;
    logic dbl;
    logic stat_armed;
    logic [7:0] shifter;
    logic [7:0] rx_buf;
    logic [3:0] bit_cnt;
    ctl_state_type ctl;
    logic sck_lvl;
    logic out_bit;
    logic [2:0] ss_sync;
    logic [2:0] sck_sync;
    logic [1:0] mosi_sync;
    logic ack;
    logic [31:0] rdata;
  } port_state_type;
  port_state_type s_q;
  port_state_type s_d;

  logic tick;
  logic route_alt;
  logic en;
  logic ctl_mode;
  logic lsb;
  logic sck_idle_level;
  logic sck_sample_phase;
  logic ss_pin;
  logic sck_pin;
  logic mosi_pin;
  logic miso_pin;
  logic sel_lo;
  logic sck_prev;
  logic sck_now;
  logic lead_edge;
  logic trail_edge;
  logic sample_now;
  logic setup_now;
  logic busy;
  logic wr;
  logic rd;
  logic data_access;
  logic [7:0] status_rd;

  // order picks end bit
  // Pick bit to shift out for current order
  function automatic logic first_bit(input logic [7:0] v, input logic lsb_first);
    first_bit = lsb_first ? v[0] : v[7];
  endfunction

  // Shift one sampled bit in
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb_first, input logic b);
    shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  sck_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(s_q.ctl != ST_IDLE),
    .rate_sel(s_q.port_ctrl[1:0]),
    .double_rate(s_q.dbl),
    .tick(tick)
  );

  always_comb begin
    route_alt = PKG_IS_32 ? s_q.misc_ctrl[`BIT_PIN_ROUTE] : ~s_q.misc_ctrl[`BIT_PIN_ROUTE];
    en = s_q.port_ctrl[`BIT_PORT_EN];
    ctl_mode = s_q.port_ctrl[`BIT_CTRL_SEL];
    lsb = s_q.port_ctrl[`BIT_ORDER_LSB];
    sck_idle_level = s_q.port_ctrl[`BIT_IDLE_LVL];
    sck_sample_phase = s_q.port_ctrl[`BIT_PHASE];
    ss_pin = s_q.ss_sync[1];
    sck_pin = s_q.sck_sync[1];
    mosi_pin = s_q.mosi_sync[1];
    // Peer answers on our own SCK, so MISO is taken unsynced
    miso_pin = route_alt ? miso_in[1] : miso_in[0];
    sel_lo = ~ss_pin;
    sck_now = s_q.sck_sync[1] ^ sck_idle_level;
    sck_prev = s_q.sck_sync[2] ^ sck_idle_level;
    lead_edge = sck_now & ~sck_prev;
    trail_edge = ~sck_now & sck_prev;
    sample_now = sck_sample_phase ? trail_edge : lead_edge;
    setup_now = sck_sample_phase ? lead_edge : trail_edge;
    busy = ctl_mode ? (s_q.ctl != ST_IDLE) : (en && sel_lo && s_q.bit_cnt != 4'h0);
    wr = avs_write && !s_q.ack;
    rd = avs_read && !s_q.ack;
    data_access = (wr || rd) && avs_address == `OFS_SHIFT_DATA;
    status_rd = {s_q.done, s_q.write_collision_flag, 5'h00, s_q.dbl};

    s_d = s_q;
    s_d.ack = (avs_read || avs_write) && !s_q.ack;
    s_d.ss_sync = {s_q.ss_sync[1:0] & 2'b11, route_alt ? ss_in[1] : ss_in[0]};
    s_d.ss_sync[1] = s_q.ss_sync[0];
    s_d.ss_sync[2] = 1'b0;
    s_d.sck_sync = {s_q.sck_sync[1:0], route_alt ? sck_in[1] : sck_in[0]};
    s_d.mosi_sync = {s_q.mosi_sync[0], route_alt ? mosi_in[1] : mosi_in[0]};

    // Register writes
    if (wr) begin
      unique case (avs_address)
        `OFS_MISC_CTRL: if (avs_byteenable[0]) s_d.misc_ctrl = avs_writedata[7:0] & 8'h93;
        `OFS_PORT_CTRL: if (avs_byteenable[0]) s_d.port_ctrl = avs_writedata[7:0];
        `OFS_PORT_STAT: if (avs_byteenable[0]) s_d.dbl = avs_writedata[`BIT_DBL];
        `OFS_SHIFT_DATA: if (avs_byteenable[0]) begin
          if (busy) begin
            s_d.write_collision_flag = 1'b1;
          end else begin
            s_d.shifter = avs_writedata[7:0];
            s_d.out_bit = first_bit(avs_writedata[7:0], lsb);
            if (ctl_mode && en) begin
              s_d.ctl = ST_LEAD;
              s_d.bit_cnt = 4'h0;
            end
          end
        end
        default: ;
      endcase
    end

    if (rd && avs_address == `OFS_PORT_STAT) begin
      s_d.stat_armed = s_q.done | s_q.write_collision_flag;
    end else if (data_access && s_q.stat_armed) begin
      s_d.done = 1'b0;
      s_d.write_collision_flag = 1'b0;
      s_d.stat_armed = 1'b0;
    end
    if (vector_taken) begin
      s_d.done = 1'b0;
    end

    if (!en) begin
      s_d.ctl = ST_IDLE;
      s_d.bit_cnt = 4'h0;
      s_d.sck_lvl = sck_idle_level;
    end else if (ctl_mode) begin
      if (!ss_dir_out && sel_lo) begin
        s_d.port_ctrl[`BIT_CTRL_SEL] = 1'b0;
        s_d.ctl = ST_IDLE;
        s_d.bit_cnt = 4'h0;
        s_d.done = 1'b1;
      end else if (tick) begin
        unique case (s_q.ctl)
          ST_LEAD: begin
            s_d.sck_lvl = ~sck_idle_level;
            if (sck_sample_phase) begin
              s_d.out_bit = first_bit(s_q.shifter, lsb);
            end else begin
              s_d.shifter = shift_in(s_q.shifter, lsb, miso_pin);
            end
            s_d.ctl = ST_TRAIL;
          end
          ST_TRAIL: begin
            s_d.sck_lvl = sck_idle_level;
            if (sck_sample_phase) begin
              s_d.shifter = shift_in(s_q.shifter, lsb, miso_pin);
            end
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            if (s_q.bit_cnt + 4'h1 == `BITS_PER_BYTE) begin
              s_d.ctl = ST_IDLE;
              s_d.done = 1'b1;
              s_d.bit_cnt = 4'h0;
              s_d.rx_buf = sck_sample_phase ? shift_in(s_q.shifter, lsb, miso_pin) : s_q.shifter;
            end else begin
              s_d.ctl = ST_LEAD;
              if (!sck_sample_phase) begin
                s_d.out_bit = first_bit(s_q.shifter, lsb);
              end
            end
          end
          default: s_d.ctl = ST_IDLE;
        endcase
      end else if (s_q.ctl == ST_IDLE) begin
        s_d.sck_lvl = sck_idle_level;
      end
    end else begin
      s_d.sck_lvl = sck_idle_level;
      if (!sel_lo) begin
        s_d.bit_cnt = 4'h0;
        s_d.out_bit = first_bit(s_q.shifter, lsb);
      end else if (sample_now) begin
        s_d.shifter = shift_in(s_q.shifter, lsb, mosi_pin);
        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        if (s_q.bit_cnt + 4'h1 == `BITS_PER_BYTE) begin
          s_d.bit_cnt = 4'h0;
          s_d.done = 1'b1;
          s_d.rx_buf = shift_in(s_q.shifter, lsb, mosi_pin);
        end
      end else if (setup_now && sck_sample_phase == 1'b0 || setup_now && s_q.bit_cnt != 4'h0 || setup_now) begin
        s_d.out_bit = first_bit(s_q.shifter, lsb);
      end
    end

    // Read data path
    if (rd) begin
      unique case (avs_address)
        `OFS_MISC_CTRL: s_d.rdata = {24'h000000, s_q.misc_ctrl};
        `OFS_PORT_CTRL: s_d.rdata = {24'h000000, s_q.port_ctrl};
        `OFS_PORT_STAT: s_d.rdata = {24'h000000, status_rd};
        `OFS_SHIFT_DATA: s_d.rdata = {24'h000000, s_q.rx_buf};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.misc_ctrl <= `RST_MISC_CTRL;
      s_q.port_ctrl <= `RST_PORT_CTRL;
      s_q.ss_sync <= 3'h7;
    end else begin
      s_q <= s_d;
      s_q.ss_sync[2] <= 1'b0;
    end
  end

  always_comb begin
    avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
    avs_readdata = s_q.rdata;
    xfer_irq = s_q.done && s_q.port_ctrl[`BIT_IRQ_EN] && global_irq_enable;
    ss_out = '0;
    sck_out = '0;
    mosi_out = '0;
    miso_out = '0;
    ss_oe_n = 2'b11;
    sck_oe_n = 2'b11;
    mosi_oe_n = 2'b11;
    miso_oe_n = 2'b11;
    if (en && ctl_mode) begin
      ss_out[route_alt] = ss_gpio_out;
      ss_oe_n[route_alt] = ~ss_dir_out;
      sck_out[route_alt] = s_q.sck_lvl;
      sck_oe_n[route_alt] = ~sck_dir_out;
      mosi_out[route_alt] = s_q.out_bit;
      mosi_oe_n[route_alt] = ~mosi_dir_out;
    end else if (en) begin
      miso_out[route_alt] = s_q.out_bit;
      miso_oe_n[route_alt] = ~(miso_dir_out && sel_lo);
    end
  end
endmodule // spi_port

// file: test/spi_port_props.sv
// Checker for the serial port top ports
`timescale 1ns/1ps
`include "spi_port_params.svh"
module spi_port_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic global_irq_enable,
  input wire logic ss_dir_out,
  input wire logic miso_dir_out,
  input wire logic [1:0] ss_in,
  input wire logic [1:0] ss_oe_n,
  input wire logic [1:0] sck_oe_n,
  input wire logic [1:0] mosi_oe_n,
  input wire logic [1:0] miso_oe_n,
  input wire logic xfer_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  chk_route_clk: assert property (sck_oe_n != 2'b00 && ss_oe_n != 2'b00)
    else $error("both pin sets drive clock or select");
  chk_route_data: assert property (mosi_oe_n != 2'b00 && miso_oe_n != 2'b00)
    else $error("both pin sets drive data");
  chk_miso_quiet: assert property (ss_in == 2'b11 [*4] |-> miso_oe_n == 2'b11)
    else $error("miso driven while deselected");
  chk_role_drop: assert property ((!ss_dir_out && ss_in == 2'b00) [*5] |-> sck_oe_n == 2'b11 && mosi_oe_n == 2'b11)
    else $error("clock or mosi driven after role loss");
  chk_irq_gate: assert property (xfer_irq |-> global_irq_enable)
    else $error("interrupt without global enable");
  chk_stat_rsvd: assert property (avs_read && !avs_waitrequest && avs_address == `OFS_PORT_STAT |-> avs_readdata[5:1] == 5'h00)
    else $error("reserved status bits set");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_sync_lag: assert property ($fell(ss_in[0]) && !avs_write && $stable(miso_dir_out) |=> $stable(miso_oe_n))
    else $error("select reacted without synchronizer");
endmodule // spi_port_props
bind spi_port spi_port_props u_spi_port_props (.*);

// file: test/spi_peer_model.sv
// Behavioural serial peripheral on the far side
`timescale 1ns/1ps
module spi_peer_model (
  input wire logic ss_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic sck_idle_level,
  input wire logic sck_sample_phase,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  int idx = 0;
  wire smp = sck ^ sck_idle_level ^ sck_sample_phase;
  wire cur = (idx < 0 || idx > 7) ? ~tx[0] : tx[lsb ? idx : 7 - idx];
  always @(negedge ss_n) begin
    idx = sck_sample_phase ? -1 : 0;
    rx = 8'h00;
  end
  always @(posedge smp) if (!ss_n) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
  always @(negedge smp) if (!ss_n) idx++;
  // Released line shows inverse
  assign miso = ss_n ? ~cur : cur;
endmodule // spi_peer_model

// file: test/tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "spi_port_params.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, global_irq_enable = 1'b0, vector_taken = 1'b0;
  logic ss_dir_out = 1'b1, mosi_dir_out = 1'b1, sck_dir_out = 1'b1, miso_dir_out = 1'b0, ss_gpio_out = 1'b1;
  logic ss_drv = 1'b1, sck_idle_level = 1'b0, sck_sample_phase = 1'b0, lsb = 1'b0, s, avs_waitrequest, xfer_irq, miso;
  logic ext_sck = 1'b0, ext_mosi = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [1:0] ss_out, ss_oe_n, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic [7:0] peer_tx = 8'h00, peer_rx, q;
  int error_cnt = 0, compares = 0, cyc = 0;
  int hp_tab[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
  wire pin_ss = ss_oe_n[0] ? ss_drv : ss_out[0];
  wire pin_sck = sck_oe_n[0] ? (sck_idle_level ^ ext_sck) : sck_out[0];
  wire pin_mosi = mosi_oe_n[0] ? ext_mosi : mosi_out[0];
  wire [1:0] ss_in = {2{pin_ss}}, sck_in = {2{pin_sck}}, mosi_in = {2{pin_mosi}}, miso_in = {2{miso}};
  always #5 clk = ~clk;
  spi_port u_spi_port (.*);
  spi_peer_model u_spi_peer_model (.ss_n(pin_ss), .sck(pin_sck), .mosi(pin_mosi), .sck_idle_level(sck_idle_level), .sck_sample_phase(sck_sample_phase),
    .lsb(lsb), .tx(peer_tx), .miso(miso), .rx(peer_rx));
  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done;
    q = 8'h00;
    while (q[7] !== 1'b1) bus(0, `OFS_PORT_STAT, 8'h00);
  endtask
  task automatic check_reset_route;
    bus(0, `OFS_MISC_CTRL, 8'h00);
    chk(q, `RST_MISC_CTRL);
    bus(0, `OFS_PORT_STAT, 8'h00);
    chk(q, `RST_PORT_STAT);
    bus(0, 4'h2, 8'h00);
    chk(q, 8'h00);
    bus(1, `OFS_MISC_CTRL, 8'h80);
    bus(1, `OFS_PORT_CTRL, 8'h50);
    chk({6'h0, sck_oe_n}, 8'h01);
    bus(1, `OFS_MISC_CTRL, 8'h00);
    chk({6'h0, sck_oe_n}, 8'h02);
  endtask
  task automatic check_modes;
    int hp;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = 8'h3c + 8'(i * 37);
      sck_idle_level = i[1];
      sck_sample_phase = i[0];
      lsb = i[2];
      peer_tx = ~d;
      bus(1, `OFS_PORT_STAT, {7'h0, i[2]});
      bus(1, `OFS_PORT_CTRL, {2'b01, i[2], 1'b1, i[1], i[0], i[1:0]});
      @(posedge clk);
      chk({7'h0, pin_sck}, {7'h0, sck_idle_level});
      ss_gpio_out <= 1'b0;
      bus(1, `OFS_SHIFT_DATA, d);
      @(pin_sck);
      s = pin_sck;
      hp = 0;
      @(negedge clk);
      while (pin_sck === s && hp < 200) begin
        hp++;
        @(negedge clk);
      end
      @(posedge clk);
      chk(8'(hp), 8'(hp_tab[i]));
      wait_done();
      chk(q, {1'b1, 6'h0, i[2]});
      bus(0, `OFS_SHIFT_DATA, 8'h00);
      chk(q, peer_tx);
      chk(peer_rx, d);
      ss_gpio_out <= 1'b1;
      bus(0, `OFS_PORT_STAT, 8'h00);
      chk(q, {7'h0, i[2]});
    end
  endtask
  task automatic check_collision;
    logic [7:0] prev;
    prev = peer_tx;
    peer_tx = 8'ha5;
    ss_gpio_out <= 1'b0;
    bus(1, `OFS_SHIFT_DATA, 8'h11);
    bus(0, `OFS_SHIFT_DATA, 8'h00);
    chk(q, prev);
    bus(1, `OFS_SHIFT_DATA, 8'h22);
    bus(0, `OFS_PORT_STAT, 8'h00);
    chk(q & 8'h40, 8'h40);
    wait_done();
    bus(0, `OFS_SHIFT_DATA, 8'h00);
    chk(q, 8'ha5);
    chk(peer_rx, 8'h11);
    bus(0, `OFS_PORT_STAT, 8'h00);
    chk(q & 8'hc0, 8'h00);
    ss_gpio_out <= 1'b1;
  endtask
  task automatic check_role_loss;
    int n;
    ss_dir_out <= 1'b0;
    global_irq_enable <= 1'b1;
    bus(1, `OFS_PORT_CTRL, 8'hd0);
    ss_drv <= 1'b0;
    n = 0;
    while (xfer_irq !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, xfer_irq}, 8'h01);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    bus(0, `OFS_PORT_CTRL, 8'h00);
    chk(q, 8'hc0);
    chk({7'h0, xfer_irq}, 8'h00);
    vector_taken <= 1'b1;
    @(posedge clk);
    vector_taken <= 1'b0;
    ss_drv <= 1'b1;
    bus(0, `OFS_PORT_STAT, 8'h00);
    chk(q & 8'h80, 8'h00);
    bus(1, `OFS_PORT_CTRL, 8'hd0);
    bus(0, `OFS_PORT_CTRL, 8'h00);
    chk(q, 8'hd0);
  endtask
  task automatic check_peripheral;
    logic [7:0] got;
    logic [7:0] pat;
    got = 8'h00;
    pat = 8'h5a;
    sck_idle_level = 1'b0;
    miso_dir_out <= 1'b1;
    bus(1, `OFS_PORT_CTRL, 8'h40);
    bus(1, `OFS_SHIFT_DATA, 8'h96);
    ss_drv <= 1'b0;
    repeat (4) @(posedge clk);
    chk({6'h0, miso_oe_n}, 8'h02);
    for (int k = 7; k >= 0; k--) begin
      ext_mosi <= pat[k];
      repeat (4) @(posedge clk);
      got[k] = miso_out[0];
      ext_sck <= 1'b1;
      repeat (4) @(posedge clk);
      ext_sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chk(got, 8'h96);
    bus(0, `OFS_PORT_STAT, 8'h00);
    chk(q & 8'h80, 8'h80);
    bus(0, `OFS_SHIFT_DATA, 8'h00);
    chk(q, 8'h5a);
    ss_drv <= 1'b1;
    repeat (4) @(posedge clk);
    chk({6'h0, miso_oe_n}, 8'h03);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_reset_route();
    check_modes();
    check_collision();
    check_role_loss();
    check_peripheral();
    print_verdict();
  end
endmodule // tb_top
